// ---- logic/period_timer.sv ----
// 8-bit period timer with prescaler, postscaler and external reset/gate source
`timescale 1ns/1ns
`include "period_timer_cfg.svh"
module period_timer
  import period_timer_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Software side
  input wire sw_ctrl_t sw_i,
  input wire logic flag_clr_i,
  input wire logic debug_freeze_i,
  // Timer tick source (already on sys_clk)
  input wire logic tick_src_i,
  // External reset/gate source from a pin
  input wire logic external_reset_signal_i,
  // Status
  output logic [`PT_CNT_W-1:0] count_register_o,
  output logic [`PT_CNT_W-1:0] period_register_o,
  output logic timer_run_bit_o,
  output logic period_pulse_out_o,
  output logic period_flag_o
);

  logic [`PT_CNT_W-1:0] count_register_ff;
  logic [`PT_CNT_W-1:0] period_register_ff;
  logic [`PT_PRE_W-1:0] pre_cnt_ff;
  logic [`PT_POST_W-1:0] post_cnt_ff;
  logic run_ff, pulse_ff, flag_ff, armed_ff;
  logic [`PT_PRE_SEL_W-1:0] pre_sel_ff;
  logic [`PT_POST_W-1:0] post_sel_ff;
  logic [`PT_MODE_W-1:0] mode_ff;
  logic [2:0] ers_sync_ff;
  logic ers_prev_ff;
  logic pend_wr_ff;
  logic [`PT_CNT_W-1:0] pend_val_ff;
  logic ers_lvl, ers_rise, ers_fall, tick, scaler_clr, hw_reset, gate_ok;
  logic trig_start, clr_cnt, match;
  logic [1:0] mode_hi;
  logic [2:0] mode_lo;
  logic nxt_run;

  // Ratio select 0..7 gives divide 1,2,4..128
  function automatic logic [`PT_PRE_W-1:0] pre_mask(input logic [`PT_PRE_SEL_W-1:0] sel);
    pre_mask = `PT_PRE_W'((8'h01 << sel) - 8'h01);
  endfunction

  // Three-stage synchroniser; stable once stages 2 and 3 agree
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ers_sync_ff <= 3'h0;
    end else begin
      ers_sync_ff <= {ers_sync_ff[1:0], external_reset_signal_i};
    end
  end

  // Filtered level, frozen while debug freeze is held
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ers_prev_ff <= 1'b0;
    end else if (!debug_freeze_i && (ers_sync_ff[1] == ers_sync_ff[2])) begin
      ers_prev_ff <= ers_sync_ff[2];
    end
  end

  assign ers_lvl = ers_prev_ff;
  assign ers_rise = !debug_freeze_i && (ers_sync_ff[1] == ers_sync_ff[2])
                    && ers_sync_ff[2] && !ers_prev_ff;
  assign ers_fall = !debug_freeze_i && (ers_sync_ff[1] == ers_sync_ff[2])
                    && !ers_sync_ff[2] && ers_prev_ff;
  assign mode_hi = mode_ff[4:3];
  assign mode_lo = mode_ff[2:0];

  // Hardware reset event and gate per mode
  always_comb begin
    hw_reset = 1'b0;
    gate_ok = 1'b1;
    trig_start = 1'b0;
    if (mode_hi == `PT_MODE_FREE) begin
      unique case (mode_lo)
        3'h1: gate_ok = ers_lvl;
        3'h2: gate_ok = !ers_lvl;
        3'h3: hw_reset = ers_rise | ers_fall;
        3'h4: hw_reset = ers_rise;
        3'h5: hw_reset = ers_fall;
        3'h6: hw_reset = !ers_lvl && !debug_freeze_i;
        3'h7: hw_reset = ers_lvl && !debug_freeze_i;
        3'h0: gate_ok = 1'b1;
      endcase
    end else begin
      unique case (mode_lo)
        3'h0: trig_start = 1'b1;
        3'h1, 3'h4, 3'h6: trig_start = ers_rise;
        3'h2, 3'h5, 3'h7: trig_start = ers_fall;
        3'h3: trig_start = ers_rise | ers_fall;
      endcase
      unique case (mode_lo)
        3'h4: hw_reset = ers_rise;
        3'h5: hw_reset = ers_fall;
        3'h6: hw_reset = !ers_lvl && !debug_freeze_i;
        3'h7: hw_reset = ers_lvl && !debug_freeze_i;
        3'h0, 3'h1, 3'h2, 3'h3: hw_reset = 1'b0;
      endcase
    end
  end

  assign scaler_clr = sw_i.cnt_we | sw_i.ctrl_we | hw_reset;
  assign tick = run_ff && armed_ff && gate_ok && tick_src_i
                && ((pre_cnt_ff & pre_mask(pre_sel_ff)) == pre_mask(pre_sel_ff));
  // Match level straight from the compare, so the clear lands on the next tick
  assign match = (count_register_ff == period_register_ff);
  assign clr_cnt = tick && match;

  // Control register fields
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_sel_ff <= 3'h0;
      post_sel_ff <= 4'h0;
      mode_ff <= 5'h00;
    end else if (sw_i.ctrl_we) begin
      pre_sel_ff <= sw_i.pre_sel;
      post_sel_ff <= sw_i.postscale_select;
      mode_ff <= sw_i.mode;
    end
  end

  // Run bit: one-shot clears it at the match, monostable keeps it
  always_comb begin
    nxt_run = run_ff;
    if (sw_i.ctrl_we) begin
      nxt_run = sw_i.run;
    end else if (clr_cnt && mode_hi == `PT_MODE_ONESHOT) begin
      nxt_run = 1'b0;
    end
  end

  // Armed once the start condition is met; monostable rearms on trigger
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      if (!nxt_run) begin
        armed_ff <= 1'b0;
      end else if (sw_i.ctrl_we && (!run_ff || sw_i.mode[4:3] != mode_hi)) begin
        armed_ff <= (sw_i.mode[4:3] == `PT_MODE_FREE);
      end else if (mode_hi == `PT_MODE_FREE) begin
        armed_ff <= 1'b1;
      end else if (clr_cnt) begin
        armed_ff <= 1'b0;
      end else if (trig_start) begin
        armed_ff <= 1'b1;
      end
    end
  end

  // Prescaler counter
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_cnt_ff <= 7'h00;
    end else if (scaler_clr) begin
      pre_cnt_ff <= 7'h00;
    end else if (run_ff && armed_ff && gate_ok && tick_src_i) begin
      pre_cnt_ff <= tick ? 7'h00 : pre_cnt_ff + 7'h01;
    end
  end

  // Period register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      period_register_ff <= `PT_PER_RST;
    end else if (sw_i.per_we) begin
      period_register_ff <= sw_i.per_wdata;
    end
  end

  // Pending software count write, applied on next prescaled tick
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_wr_ff <= 1'b0;
      pend_val_ff <= `PT_CNT_RST;
    end else if (sw_i.cnt_we) begin
      pend_wr_ff <= 1'b1;
      pend_val_ff <= sw_i.cnt_wdata;
    end else if (tick || hw_reset) begin
      pend_wr_ff <= 1'b0;
    end
  end

  // Count register; control writes never touch it
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_register_ff <= `PT_CNT_RST;
    end else begin
      if (hw_reset) begin
        count_register_ff <= `PT_CNT_RST;
      end else if (tick && pend_wr_ff) begin
        count_register_ff <= pend_val_ff;
      end else if (clr_cnt) begin
        count_register_ff <= `PT_CNT_RST;
      end else if (tick) begin
        count_register_ff <= count_register_ff + 8'h01;
      end
    end
  end

  // Postscaler and period pulse
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      post_cnt_ff <= 4'h0;
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= 1'b0;
      if (scaler_clr) begin
        post_cnt_ff <= 4'h0;
      end else if (clr_cnt) begin
        if (post_cnt_ff == post_sel_ff) begin
          post_cnt_ff <= 4'h0;
          pulse_ff <= 1'b1;
        end else begin
          post_cnt_ff <= post_cnt_ff + 4'h1;
        end
      end
    end
  end

  // Sticky flag; a new pulse wins over a clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_ff <= 1'b0;
    end else if (pulse_ff) begin
      flag_ff <= 1'b1;
    end else if (flag_clr_i) begin
      flag_ff <= 1'b0;
    end
  end

  assign count_register_o = count_register_ff;
  assign period_register_o = period_register_ff;
  assign timer_run_bit_o = run_ff;
  assign period_pulse_out_o = pulse_ff;
  assign period_flag_o = flag_ff;

endmodule

// ---- logic/period_timer_cfg.svh ----
// Constants for the 8-bit period timer
`ifndef PERIOD_TIMER_CFG_SVH
`define PERIOD_TIMER_CFG_SVH
`define PT_CNT_W 8
`define PT_CNT_RST 8'h00
`define PT_PER_RST 8'hFF
`define PT_PRE_W 7
`define PT_PRE_SEL_W 3
`define PT_POST_W 4
`define PT_MODE_W 5
`define PT_MODE_FREE 2'h0
`define PT_MODE_ONESHOT 2'h1
`define PT_MODE_MONO 2'h2
`endif

// ---- logic/period_timer_pkg.sv ----
// Types for the 8-bit period timer
`include "period_timer_cfg.svh"
package period_timer_pkg;
  // Software writes toward the timer
  typedef struct packed {
    logic cnt_we;
    logic [`PT_CNT_W-1:0] cnt_wdata;
    logic per_we;
    logic [`PT_CNT_W-1:0] per_wdata;
    logic ctrl_we;
    logic run;
    logic [`PT_PRE_SEL_W-1:0] pre_sel;
    logic [`PT_POST_W-1:0] postscale_select;
    logic [`PT_MODE_W-1:0] mode;
  } sw_ctrl_t;
  // One-shot sequencing
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} run_state_t;
endpackage

// ---- tb/ext_source_model.sv ----
// External reset source model with minimum spacing between changes
`timescale 1ns/1ns
module ext_source_model (
  // Clock and wanted level
  input wire logic sys_clk_i,
  input wire logic want_i,
  // Pin toward the timer
  output logic ext_o
);
  int hold_cnt = 0;
  initial ext_o = 1'b0;
  // Follow the wanted level, at most one change per seven ticks
  always @(posedge sys_clk_i) begin
    #1;
    if (want_i != ext_o && hold_cnt >= 6) begin
      ext_o = want_i;
      hold_cnt = 0;
    end else if (hold_cnt < 100) begin
      hold_cnt++;
    end
  end
endmodule

// ---- tb/period_timer_sva.sv ----
// Port assertions for the period timer
`timescale 1ns/1ns
`include "period_timer_cfg.svh"
module period_timer_sva
  import period_timer_pkg::*;
(
  // Clock, reset and inputs
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire sw_ctrl_t sw_i,
  input wire logic flag_clr_i,
  input wire logic tick_src_i,
  // Outputs watched
  input wire logic [`PT_CNT_W-1:0] count_register_o,
  input wire logic [`PT_CNT_W-1:0] period_register_o,
  input wire logic timer_run_bit_o,
  input wire logic period_pulse_out_o,
  input wire logic period_flag_o
);
  logic [4:0] mode_ff;
  logic [2:0] pre_ff;
  logic pend_ff;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Last control write and pending count load
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_ff <= 5'h00;
      pre_ff <= 3'h0;
      pend_ff <= 1'b0;
    end else begin
      if (sw_i.ctrl_we) begin
        mode_ff <= sw_i.mode;
        pre_ff <= sw_i.pre_sel;
      end
      pend_ff <= sw_i.cnt_we | (pend_ff & ~tick_src_i);
    end
  end
  chk_reset_vals: assert property ($rose(rstn_i) |-> count_register_o == 8'h00 &&
    period_register_o == 8'hFF && !timer_run_bit_o) else $error("bad reset values");
  chk_period_write: assert property (sw_i.per_we |=>
    period_register_o == $past(sw_i.per_wdata)) else $error("period write lost");
  chk_count_step: assert property (timer_run_bit_o && tick_src_i && pre_ff == 3'h0 &&
    mode_ff == 5'h00 && count_register_o < period_register_o && !pend_ff && !sw_i.cnt_we &&
    !sw_i.ctrl_we && !sw_i.per_we |=> count_register_o == $past(count_register_o) + 8'h01)
    else $error("count did not step");
  chk_ctrl_keep: assert property (sw_i.ctrl_we && !tick_src_i && !sw_i.cnt_we &&
    mode_ff == 5'h00 && sw_i.mode == 5'h00 |=> $stable(count_register_o))
    else $error("control write moved count");
  chk_pulse_single: assert property (period_pulse_out_o |=> !period_pulse_out_o)
    else $error("period pulse too wide");
  chk_flag_set: assert property (period_pulse_out_o && !flag_clr_i |=> period_flag_o)
    else $error("flag not set");
  chk_flag_sticky: assert property (period_flag_o && !flag_clr_i |=> period_flag_o)
    else $error("flag dropped");
  chk_oneshot_stop: assert property (period_pulse_out_o && mode_ff[4:3] == 2'b01 |->
    ##[0:4] !timer_run_bit_o) else $error("one-shot kept running");
  chk_mono_keep: assert property (period_pulse_out_o && mode_ff[4:3] == 2'b10 &&
    !sw_i.ctrl_we |-> timer_run_bit_o) else $error("monostable run bit cleared");
endmodule
bind period_timer period_timer_sva i_sva (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sw_i(sw_i),
  .flag_clr_i(flag_clr_i), .tick_src_i(tick_src_i), .count_register_o(count_register_o),
  .period_register_o(period_register_o), .timer_run_bit_o(timer_run_bit_o),
  .period_pulse_out_o(period_pulse_out_o), .period_flag_o(period_flag_o));

// ---- tb/period_timer_test.sv ----
// Self-checking testbench for the period timer
`timescale 1ns/1ns
module period_timer_test;
  import period_timer_pkg::*;
  logic sys_clk, rstn, flag_clr, freeze, tick, want, ext, run, pulse, flag;
  sw_ctrl_t sw;
  logic [7:0] cnt, per, c, v;
  logic [3:0] s;
  logic [2:0] p;
  int n, num_errors = 0, checks_done = 0;
  period_timer i_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .sw_i(sw), .flag_clr_i(flag_clr),
    .debug_freeze_i(freeze), .tick_src_i(tick), .external_reset_signal_i(ext),
    .count_register_o(cnt), .period_register_o(per), .timer_run_bit_o(run),
    .period_pulse_out_o(pulse), .period_flag_o(flag));
  ext_source_model i_src (.sys_clk_i(sys_clk), .want_i(want), .ext_o(ext));
  // Clock
  always #2 sys_clk = ~sys_clk;
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic ctrl(input logic r, input logic [2:0] pp, input logic [3:0] ss,
                      input logic [4:0] m);
    sw.run = r;
    sw.pre_sel = pp;
    sw.postscale_select = ss;
    sw.mode = m;
    sw.ctrl_we = 1'b1;
    step(1);
    sw.ctrl_we = 1'b0;
  endtask
  task automatic wr(input logic to_cnt, input logic [7:0] d);
    sw.cnt_we = to_cnt;
    sw.per_we = !to_cnt;
    sw.cnt_wdata = d;
    sw.per_wdata = d;
    step(1);
    sw.cnt_we = 1'b0;
    sw.per_we = 1'b0;
  endtask
  task automatic wait_pulse(output int k);
    k = 0;
    while (pulse !== 1'b1 && k < 5000) begin
      step(1);
      k++;
    end
    chk("pulse_seen", 1'b1, pulse);
    step(1);
  endtask
  task automatic summarize();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    sys_clk = 0;
    rstn = 0;
    sw = '0;
    {flag_clr, freeze, want} = 3'h0;
    tick = 1;
    step(5);
    rstn = 1;
    chk("count", 8'h00, cnt);
    chk("period", 8'hFF, per);
    wr(1'b0, 8'h05);
    chk("period", 8'h05, per);
    for (int i = 0; i < 10; i++) begin
      p = (i < 8) ? i[2:0] : 3'h0;
      s = (i == 8) ? 4'hF : 4'h0;
      v = (i == 9) ? 8'hFF : ((i == 8) ? 8'h05 : 8'h01);
      wr(1'b0, v);
      ctrl(1'b1, p, s, 5'h00);
      wait_pulse(n);
      wait_pulse(n);
      chk("gap", (int'(v) + 1) * (int'(s) + 1) * (1 << p) - 1, n);
    end
    chk("flag", 1, flag);
    tick = 0;
    flag_clr = 1;
    ctrl(1'b1, 3'h0, 4'h0, 5'h00);
    flag_clr = 0;
    step(1);
    c = cnt;
    ctrl(1'b1, 3'h0, 4'h0, 5'h00);
    chk("flag_clr", 0, flag);
    chk("ctrl_keep", c, cnt);
    wr(1'b1, 8'h03);
    step(1);
    chk("cnt_defer", c, cnt);
    tick = 1;
    step(1);
    tick = 0;
    step(1);
    chk("cnt_load", 8'h03, cnt);
    tick = 1;
    step(4);
    chk("cnt_step", 8'h07, cnt);
    want = 1;
    ctrl(1'b1, 3'h0, 4'h0, 5'h01);
    step(15);
    want = 0;
    step(12);
    c = cnt;
    step(10);
    chk("gate_hold", c, cnt);
    want = 1;
    step(12);
    chk("gate_run", 1, cnt !== c);
    ctrl(1'b1, 3'h0, 4'h0, 5'h07);
    step(10);
    chk("level_reset", 8'h00, cnt);
    want = 0;
    step(12);
    freeze = 1;
    want = 1;
    step(12);
    chk("freeze", 1, cnt !== 8'h00);
    freeze = 0;
    want = 0;
    step(12);
    ctrl(1'b1, 3'h0, 4'h0, 5'h04);
    step(12);
    want = 1;
    step(6);
    chk("edge_reset", 1, cnt < 8'h04);
    c = cnt;
    step(3);
    chk("edge_once", c + 8'h03, cnt);
    want = 0;
    wr(1'b0, 8'h03);
    ctrl(1'b1, 3'h0, 4'h0, 5'h08);
    wait_pulse(n);
    step(3);
    chk("oneshot_run", 0, run);
    c = cnt;
    step(5);
    chk("oneshot_hold", c, cnt);
    ctrl(1'b1, 3'h0, 4'h0, 5'h11);
    want = 1;
    wait_pulse(n);
    chk("mono_run", 1, run);
    want = 0;
    step(12);
    want = 1;
    wait_pulse(n);
    chk("mono_again", 1, n < 100);
    summarize();
  end
endmodule
